// *** core/bsb_pkg.sv ***
/*
 * Package for the backlight sync/dither/boost configuration bank:
 * register offsets, field positions, reset values and decode constants.
 * Assumes a 32-bit AXI4-Lite register bus and a single core clock.
 */
`default_nettype none

package bsb_pkg;

   // ==========================================================
   // Register indices; the bus byte address is four times the index
   // ==========================================================
   localparam logic [7:0] OFS_SYNC_DITHER_BOOST = 8'hA5;
   localparam logic [7:0] OFS_LOCK_COUNT_UPPER  = 8'hA6;
   localparam logic [7:0] OFS_LOCK_LOWER_INPUT  = 8'hA7;
   localparam logic [7:0] OFS_RATE_CONFIG       = 8'hA8;  // Holds resolution and rate code
   localparam int         REG_IDX_BITS          = 8;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int BIT_SYNC_EN      = 7;
   localparam int DITHER_HI        = 6;
   localparam int DITHER_LO        = 5;
   localparam int BOOST_HI         = 4;
   localparam int BOOST_LO         = 0;
   localparam int LOCK_LOW_HI      = 7;
   localparam int LOCK_LOW_LO      = 3;
   localparam int BIT_FREQ_RES     = 2;
   localparam int HYST_HI          = 1;
   localparam int HYST_LO          = 0;
   localparam int RESO_HI          = 7;
   localparam int RESO_LO          = 6;
   localparam int RATE_HI          = 4;
   localparam int RATE_LO          = 0;
   localparam int LOCK_WIDTH       = 13;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] RST_SYNC_DITHER_BOOST = 8'h00;
   localparam logic [7:0] RST_LOCK_COUNT_UPPER  = 8'h00;
   localparam logic [7:0] RST_LOCK_LOWER_INPUT  = 8'h00;
   localparam logic [7:0] RST_RATE_CONFIG       = 8'h00;

   // ==========================================================
   // Decode constants
   // ==========================================================
   localparam logic [5:0] BOOST_BASE_VOLTS = 6'h0A;   // 10 V at code zero
   localparam logic [5:0] BOOST_MAX_VOLTS  = 6'h28;   // 40 V ceiling
   localparam logic [1:0] AXI_OKAY         = 2'h0;
   localparam logic [1:0] AXI_SLVERR       = 2'h2;

   // Bus write request carrier
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } bsb_wreq_t;

   // Decoded configuration handed to the core logic
   typedef struct packed {
      logic                  sync_en;
      logic [1:0]            dither_bits;
      logic [4:0]            boost_target_code;
      logic [5:0]            boost_volts;
      logic [LOCK_WIDTH-1:0] lock_count;
      logic                  freq_resistor_select;
      logic [1:0]            hyst_mode;
      logic [1:0]            resolution;
      logic [4:0]            pwm_rate_code;
   } bsb_cfg_t;

endpackage : bsb_pkg

`default_nettype wire

// *** core/bsb_timing_sel.sv ***
/*
 * Timing source selector: picks the lock divisor for the PLL when frame
 * sync is on, otherwise zero for the free-running source; picks the PLL
 * reference, the PWM rate source and the hysteresis input mask.
 * Assumes a decoded configuration from the register bank.
 */
`timescale 1ns/1ps
`default_nettype none

module bsb_timing_sel (
   input  wire logic            core_clk_i,     // Core clock
   input  wire logic            rst_n_i,        // Async reset, active low
   input  var  bsb_pkg::bsb_cfg_t cfg_i,        // Decoded configuration
   output logic                 pll_track_o,    // PLL follows frame sync
   output logic [12:0]          pll_divisor_o,  // Counter value in use
   output logic [1:0]           pll_ref_sel_o,  // 5/10/20/40 MHz select
   output logic [5:0]           pll_mult_o,     // 26/50/98 divided by 2, 0 for 196
   output logic                 rate_from_res_o,// Rate from resistor
   output logic [4:0]           rate_code_o,    // Stored rate code in use
   output logic [12:0]          hyst_mask_o     // Input bits ignored
);

   typedef struct packed {
      logic        track;
      logic [12:0] div;
      logic [1:0]  ref_sel;
      logic [5:0]  mult;
      logic        res;
      logic [4:0]  rate;
      logic [12:0] mask;
   } bsb_tsel_t;

   bsb_tsel_t st_ff;
   bsb_tsel_t nxt_st;

   // Half of the per-reference multiplier (26, 50, 98, 196)
   function automatic logic [5:0] ref_mult(input logic [1:0] sel);
      case (sel)
         2'h0:    ref_mult = 6'h0D;
         2'h1:    ref_mult = 6'h19;
         2'h2:    ref_mult = 6'h31;
         default: ref_mult = 6'h00;   // 196/2 = 98 does not fit; flagged by zero
      endcase
   endfunction : ref_mult

   // Next-state selection
   always_comb
   begin
      nxt_st         = st_ff;
      nxt_st.track   = cfg_i.sync_en;
      nxt_st.div     = cfg_i.sync_en ? cfg_i.lock_count : 13'h0000;
      nxt_st.ref_sel = cfg_i.resolution;
      nxt_st.mult    = ref_mult(cfg_i.resolution);
      nxt_st.res     = cfg_i.freq_resistor_select;
      nxt_st.rate    = cfg_i.freq_resistor_select ? 5'h00 : cfg_i.pwm_rate_code;
      case (cfg_i.hyst_mode)
         2'h0:    nxt_st.mask = 13'h0000;
         2'h1:    nxt_st.mask = 13'h0003;   // 13-bit input down to 11
         2'h2:    nxt_st.mask = 13'h0007;   // Down to 10 bits
         2'h3:    nxt_st.mask = 13'h001F;   // Down to 8 bits
         default: nxt_st.mask = 13'h0000;
      endcase
   end

   // State register
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign pll_track_o     = st_ff.track;
   assign pll_divisor_o   = st_ff.div;
   assign pll_ref_sel_o   = st_ff.ref_sel;
   assign pll_mult_o      = st_ff.mult;
   assign rate_from_res_o = st_ff.res;
   assign rate_code_o     = st_ff.rate;
   assign hyst_mask_o     = st_ff.mask;

endmodule : bsb_timing_sel

`default_nettype wire

// *** core/bsb_config_regs.sv ***
/*
 * Configuration register bank for backlight sync, dither and boost,
 * reached over AXI4-Lite, with decoded outputs and the timing selector.
 * Assumes an AXI4-Lite master keeping one write and one read in flight.
 */
// Local design decision: register access over AXI4-Lite.
// Operation
// - Dither field gives zero to three bits
// - Boost is 10 V plus code, capped 40 V
// - Upper word holds lock count bits 12:5
// - Lower bits 7:3 hold count bits 4:0
// - Lock count used only while sync enabled
// - Resistor select bit chooses rate source
// - Hysteresis field suppresses small input changes
// - Hysteresis codes: off, 11, 10, 8 bits
// - Resolution picks reference and multiplier
// - Without resistor, stored rate code sets rate
`timescale 1ns/1ps
`default_nettype none

module bsb_config_regs (
   input  wire logic        core_clk_i,       // 250 MHz core clock
   input  wire logic        rst_n_i,          // Async reset, active low
   // AXI4-Lite write address
   input  wire logic [31:0] s_axi_awaddr_i,   // Write address
   input  wire logic        s_axi_awvalid_i,  // Write address valid
   output logic             s_axi_awready_o,  // Write address ready
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata_i,    // Write data
   input  wire logic [3:0]  s_axi_wstrb_i,    // Byte strobes
   input  wire logic        s_axi_wvalid_i,   // Write data valid
   output logic             s_axi_wready_o,   // Write data ready
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp_o,    // Write response
   output logic             s_axi_bvalid_o,   // Write response valid
   input  wire logic        s_axi_bready_i,   // Write response ready
   // AXI4-Lite read address
   input  wire logic [31:0] s_axi_araddr_i,   // Read address
   input  wire logic        s_axi_arvalid_i,  // Read address valid
   output logic             s_axi_arready_o,  // Read address ready
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata_o,    // Read data
   output logic [1:0]       s_axi_rresp_o,    // Read response
   output logic             s_axi_rvalid_o,   // Read data valid
   input  wire logic        s_axi_rready_i,   // Read data ready
   // Core-facing configuration
   output logic             frame_sync_en_o,  // Frame sync drives PLL
   output logic [1:0]       dither_bits_o,    // Extra dither bits
   output logic [4:0]       boost_target_code_o, // Raw boost code
   output logic [5:0]       boost_volts_o,    // Boost target in volts
   output logic             pll_track_o,      // PLL tracking frame sync
   output logic [12:0]      pll_divisor_o,    // Lock count in use
   output logic [1:0]       pll_ref_sel_o,    // Reference select
   output logic [5:0]       pll_mult_o,       // Half multiplier
   output logic             rate_from_res_o,  // Rate from rate_set_resistor
   output logic [4:0]       pwm_rate_code_o,  // Stored rate code in use
   output logic [12:0]      hyst_mask_o       // Input LSBs ignored
);

   typedef struct packed {
      logic [7:0]  sync_dither_boost;
      logic [7:0]  lock_count_upper;
      logic [7:0]  lock_lower_input;
      logic [7:0]  rate_config;
      bsb_pkg::bsb_wreq_t wreq;
      logic        aw_held;
      logic        w_held;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } bsb_regs_t;

   bsb_regs_t         st_ff;
   bsb_regs_t         nxt_st;
   bsb_pkg::bsb_cfg_t cfg;

   // One aligned word per register: word index is the byte address over four
   function automatic logic [2:0] reg_sel(input logic [31:0] addr);
      if (addr[31:10] != 22'h000000)
         reg_sel = 3'h7;
      else if (addr[9:2] == bsb_pkg::OFS_SYNC_DITHER_BOOST)
         reg_sel = 3'h0;
      else if (addr[9:2] == bsb_pkg::OFS_LOCK_COUNT_UPPER)
         reg_sel = 3'h1;
      else if (addr[9:2] == bsb_pkg::OFS_LOCK_LOWER_INPUT)
         reg_sel = 3'h2;
      else if (addr[9:2] == bsb_pkg::OFS_RATE_CONFIG)
         reg_sel = 3'h3;
      else
         reg_sel = 3'h7;
   endfunction : reg_sel

   // ==========================================================
   // Bus handshakes
   // ==========================================================
   assign s_axi_awready_o = !st_ff.aw_held && !st_ff.bvalid;
   assign s_axi_wready_o  = !st_ff.w_held && !st_ff.bvalid;
   assign s_axi_arready_o = !st_ff.rvalid;
   assign s_axi_bvalid_o  = st_ff.bvalid;
   assign s_axi_bresp_o   = st_ff.bresp;
   assign s_axi_rvalid_o  = st_ff.rvalid;
   assign s_axi_rdata_o   = st_ff.rdata;
   assign s_axi_rresp_o   = st_ff.rresp;

   // ==========================================================
   // Next state: capture, write, read
   // ==========================================================
   always_comb
   begin
      logic        aw_now;
      logic        w_now;
      logic [31:0] waddr;
      logic [31:0] wdat;
      logic [3:0]  wstb;
      logic [7:0]  wbyte;
      logic        wlane_en;
      logic [7:0]  rbyte;
      logic [2:0]  rsel;
      aw_now   = 1'b0;
      w_now    = 1'b0;
      waddr    = 32'h00000000;
      wdat     = 32'h00000000;
      wstb     = 4'h0;
      wbyte    = 8'h00;
      wlane_en = 1'b0;
      rbyte    = 8'h00;
      rsel     = 3'h7;
      nxt_st   = st_ff;

      aw_now = s_axi_awvalid_i && s_axi_awready_o;
      w_now  = s_axi_wvalid_i && s_axi_wready_o;
      if (aw_now)
      begin
         nxt_st.wreq.addr = s_axi_awaddr_i;
         nxt_st.aw_held   = 1'b1;
      end
      if (w_now)
      begin
         nxt_st.wreq.data = s_axi_wdata_i;
         nxt_st.wreq.strb = s_axi_wstrb_i;
         nxt_st.w_held    = 1'b1;
      end

      // Write commits once address and data have both arrived
      if (nxt_st.aw_held && nxt_st.w_held)
      begin
         waddr    = nxt_st.wreq.addr;
         wdat     = nxt_st.wreq.data;
         wstb     = nxt_st.wreq.strb;
         wbyte    = wdat[7:0];
         wlane_en = wstb[0];
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held  = 1'b0;
         nxt_st.bvalid  = 1'b1;
         nxt_st.bresp   = bsb_pkg::AXI_OKAY;
         case (reg_sel(waddr))
            3'h0:
            begin
               if (wlane_en) nxt_st.sync_dither_boost = wbyte;
            end
            3'h1:
            begin
               if (wlane_en) nxt_st.lock_count_upper = wbyte;
            end
            3'h2:
            begin
               if (wlane_en) nxt_st.lock_lower_input = wbyte;
            end
            3'h3:
            begin
               if (wlane_en) nxt_st.rate_config = wbyte;
            end
            default: nxt_st.bresp = bsb_pkg::AXI_SLVERR;
         endcase
      end
      if (st_ff.bvalid && s_axi_bready_i)
         nxt_st.bvalid = 1'b0;

      // Read: answer one cycle after the address is taken
      if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         rsel = reg_sel(s_axi_araddr_i);
         case (rsel)
            3'h0:    rbyte = st_ff.sync_dither_boost;
            3'h1:    rbyte = st_ff.lock_count_upper;
            3'h2:    rbyte = st_ff.lock_lower_input;
            3'h3:    rbyte = st_ff.rate_config;
            default: rbyte = 8'h00;
         endcase
         nxt_st.rdata  = {24'h000000, rbyte};
         nxt_st.rresp  = (rsel == 3'h7) ? bsb_pkg::AXI_SLVERR : bsb_pkg::AXI_OKAY;
         nxt_st.rvalid = 1'b1;
      end
      else if (st_ff.rvalid && s_axi_rready_i)
      begin
         nxt_st.rvalid = 1'b0;
      end
   end

   // State register
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_ff                   <= '0;
         st_ff.sync_dither_boost <= bsb_pkg::RST_SYNC_DITHER_BOOST;
         st_ff.lock_count_upper  <= bsb_pkg::RST_LOCK_COUNT_UPPER;
         st_ff.lock_lower_input  <= bsb_pkg::RST_LOCK_LOWER_INPUT;
         st_ff.rate_config       <= bsb_pkg::RST_RATE_CONFIG;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Field decode
   // ==========================================================
   always_comb
   begin
      logic [5:0] volts;
      volts                     = bsb_pkg::BOOST_BASE_VOLTS
                                  + {1'b0, st_ff.sync_dither_boost[bsb_pkg::BOOST_HI:bsb_pkg::BOOST_LO]};
      cfg.sync_en               = st_ff.sync_dither_boost[bsb_pkg::BIT_SYNC_EN];
      cfg.dither_bits           = st_ff.sync_dither_boost[bsb_pkg::DITHER_HI:bsb_pkg::DITHER_LO];
      cfg.boost_target_code     = st_ff.sync_dither_boost[bsb_pkg::BOOST_HI:bsb_pkg::BOOST_LO];
      cfg.boost_volts           = (volts > bsb_pkg::BOOST_MAX_VOLTS) ? bsb_pkg::BOOST_MAX_VOLTS : volts;
      cfg.lock_count            = {st_ff.lock_count_upper,
                                   st_ff.lock_lower_input[bsb_pkg::LOCK_LOW_HI:bsb_pkg::LOCK_LOW_LO]};
      cfg.freq_resistor_select  = st_ff.lock_lower_input[bsb_pkg::BIT_FREQ_RES];
      cfg.hyst_mode             = st_ff.lock_lower_input[bsb_pkg::HYST_HI:bsb_pkg::HYST_LO];
      cfg.resolution            = st_ff.rate_config[bsb_pkg::RESO_HI:bsb_pkg::RESO_LO];
      cfg.pwm_rate_code         = st_ff.rate_config[bsb_pkg::RATE_HI:bsb_pkg::RATE_LO];
   end

   assign frame_sync_en_o     = cfg.sync_en;
   assign dither_bits_o       = cfg.dither_bits;
   assign boost_target_code_o = cfg.boost_target_code;
   assign boost_volts_o       = cfg.boost_volts;

   // Timing source selection
   bsb_timing_sel u_timing_sel (
      .core_clk_i      (core_clk_i),
      .rst_n_i         (rst_n_i),
      .cfg_i           (cfg),
      .pll_track_o     (pll_track_o),
      .pll_divisor_o   (pll_divisor_o),
      .pll_ref_sel_o   (pll_ref_sel_o),
      .pll_mult_o      (pll_mult_o),
      .rate_from_res_o (rate_from_res_o),
      .rate_code_o     (pwm_rate_code_o),
      .hyst_mask_o     (hyst_mask_o)
   );

endmodule : bsb_config_regs

`default_nettype wire

// *** verif/bsb_config_props.sv ***
/*
 * Checker for the configuration bank: decode and timing-select relations
 * and AXI4-Lite answer holding, seen at the top module's ports.
 * Assumes one core clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module bsb_config_props (
   input wire logic        core_clk_i,          // Core clock
   input wire logic        rst_n_i,             // Reset, active low
   input wire logic        s_axi_bvalid_o,      // Write answer valid
   input wire logic        s_axi_bready_i,      // Write answer ready
   input wire logic [1:0]  s_axi_bresp_o,       // Write answer code
   input wire logic        s_axi_arready_o,     // Read address ready
   input wire logic        s_axi_rvalid_o,      // Read answer valid
   input wire logic        frame_sync_en_o,     // Sync enable
   input wire logic [4:0]  boost_target_code_o, // Boost code
   input wire logic [5:0]  boost_volts_o,       // Boost volts
   input wire logic        pll_track_o,         // PLL tracking
   input wire logic [12:0] pll_divisor_o,       // Counter in use
   input wire logic [1:0]  pll_ref_sel_o,       // Reference select
   input wire logic [5:0]  pll_mult_o,          // Half multiplier
   input wire logic        rate_from_res_o,     // Rate from resistor
   input wire logic [4:0]  pwm_rate_code_o,     // Rate code in use
   input wire logic [12:0] hyst_mask_o          // Ignored input bits
);
   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   // Volts follow the code with a ceiling
   property p_boost_volts;
      boost_volts_o == ((boost_target_code_o > 5'h1D) ? 6'h28 : 6'h0A + {1'b0, boost_target_code_o});
   endproperty
   a_boost_volts: assert property (p_boost_volts) else $error("boost volts wrong");

   property p_track;
      pll_track_o == $past(frame_sync_en_o);
   endproperty
   a_track: assert property (p_track) else $error("tracking not one cycle after enable");

   // Counter value unused while sync is off
   property p_div_off;
      !frame_sync_en_o |=> pll_divisor_o == 13'h0000;
   endproperty
   a_div_off: assert property (p_div_off) else $error("divisor used while sync off");

   property p_rate_res;
      rate_from_res_o |-> pwm_rate_code_o == 5'h00;
   endproperty
   a_rate_res: assert property (p_rate_res) else $error("rate code used with resistor");

   property p_hyst;
      hyst_mask_o inside {13'h0000, 13'h0003, 13'h0007, 13'h001F};
   endproperty
   a_hyst: assert property (p_hyst) else $error("bad hysteresis mask");

   // Multiplier matches the reference, once out of reset
   property p_mult;
      $past(rst_n_i) |-> pll_mult_o == (pll_ref_sel_o == 2'h0 ? 6'h0D : pll_ref_sel_o == 2'h1 ? 6'h19 :
                                        pll_ref_sel_o == 2'h2 ? 6'h31 : 6'h00);
   endproperty
   a_mult: assert property (p_mult) else $error("multiplier wrong");

   property p_bhold;
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");

   property p_arblock;
      s_axi_rvalid_o |-> !s_axi_arready_o;
   endproperty
   a_arblock: assert property (p_arblock) else $error("read taken while answer pending");

endmodule : bsb_config_props

bind bsb_config_regs bsb_config_props u_props (.core_clk_i, .rst_n_i, .s_axi_bvalid_o, .s_axi_bready_i,
   .s_axi_bresp_o, .s_axi_arready_o, .s_axi_rvalid_o, .frame_sync_en_o, .boost_target_code_o, .boost_volts_o,
   .pll_track_o, .pll_divisor_o, .pll_ref_sel_o, .pll_mult_o, .rate_from_res_o, .pwm_rate_code_o, .hyst_mask_o);

`default_nettype wire

// *** verif/testbench.sv ***
/*
 * Bench for the configuration bank: reset, a table of configurations, then
 * sync-off, strobe, unmapped and mid-run reset cases.
 * Assumes the bank answers on AXI4-Lite with one aligned word per register.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   typedef struct packed {
      logic [7:0]  a5, a6, a7, a8;
      logic [5:0]  v;
      logic [12:0] dv;
      logic [5:0]  m;
      logic [12:0] hm;
      logic [4:0]  rc;
   } bsb_row_t;

   // ==========================================================
   // Signals and design
   // ==========================================================
   logic        clk = 1'b0, rst_n = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic [3:0]  wstrb = '0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, fs_en, track, from_res;
   logic [1:0]  bresp, rresp, dith, ref_sel;
   logic [4:0]  code, rate;
   logic [5:0]  volts, mult;
   logic [12:0] div, hm;
   int          err_total = 0, checked = 0;
   logic [7:0]  ofs [4] = '{bsb_pkg::OFS_SYNC_DITHER_BOOST, bsb_pkg::OFS_LOCK_COUNT_UPPER,
                            bsb_pkg::OFS_LOCK_LOWER_INPUT, bsb_pkg::OFS_RATE_CONFIG};
   bsb_row_t    rows [4] = '{
      '{8'h00, 8'h64, 8'h28, 8'h11, 6'h0A, 13'h0000, 6'h0D, 13'h0000, 5'h11},
      '{8'hBD, 8'h64, 8'h29, 8'h43, 6'h27, 13'h0C85, 6'h19, 13'h0003, 5'h03},
      '{8'hDE, 8'h53, 8'h5A, 8'h9F, 6'h28, 13'h0A6B, 6'h31, 13'h0007, 5'h1F},
      '{8'hFF, 8'hFF, 8'hFF, 8'hC7, 6'h28, 13'h1FFF, 6'h00, 13'h001F, 5'h00}};

   // Clock of 4 ns
   always #2 clk = ~clk;

   bsb_config_regs dut (.core_clk_i(clk), .rst_n_i(rst_n),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .frame_sync_en_o(fs_en), .dither_bits_o(dith), .boost_target_code_o(code), .boost_volts_o(volts),
      .pll_track_o(track), .pll_divisor_o(div), .pll_ref_sel_o(ref_sel), .pll_mult_o(mult),
      .rate_from_res_o(from_res), .pwm_rate_code_o(rate), .hyst_mask_o(hm));

   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Write: ready seen settled before the rising edge that takes it; bready held high
   task automatic axi_write(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
                            input logic [1:0] er);
      logic hs_aw, hs_w, done;
      logic [1:0] r;
      done = 1'b0;
      awaddr <= a; wdata <= {4{d}}; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++)
      begin
         @(negedge clk);
         hs_aw = awvalid && awready;
         hs_w = wvalid && wready;
         done = bvalid && bready;
         r = bresp;
         @(posedge clk);
         if (hs_aw) awvalid <= 1'b0;
         if (hs_w) wvalid <= 1'b0;
      end
      if (!done)
      begin
         err_total++;
         report_and_stop();
      end
      check(r, er);
   endtask : axi_write

   task automatic axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic hs, done;
      logic [31:0] d;
      logic [1:0] r;
      done = 1'b0;
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (int n = 0; n < 40 && !done; n++)
      begin
         @(negedge clk);
         hs = arvalid && arready;
         done = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (hs) arvalid <= 1'b0;
      end
      if (!done)
      begin
         err_total++;
         report_and_stop();
      end
      check(d, ed);
      check(r, er);
   endtask : axi_read

   // Register access by table index; byte address is four times the register index in ofs
   task automatic wr(input int k, input logic [7:0] b);
      axi_write({22'h0, ofs[k], 2'h0}, b, 4'h1, bsb_pkg::AXI_OKAY);
   endtask : wr

   task automatic rd(input int k, input logic [7:0] b);
      axi_read({22'h0, ofs[k], 2'h0}, {24'h0, b}, bsb_pkg::AXI_OKAY);
   endtask : rd

   // ==========================================================
   // Sequence
   // ==========================================================
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 4; k++) rd(k, 8'h00);
      check(volts, 6'h0A);
      $display("test reset done");
      foreach (rows[i])
      begin
         wr(0, rows[i].a5);
         wr(1, rows[i].a6);
         wr(2, rows[i].a7);
         wr(3, rows[i].a8);
         rd(0, rows[i].a5);
         rd(1, rows[i].a6);
         rd(2, rows[i].a7);
         rd(3, rows[i].a8);
         repeat (2) @(posedge clk);
         @(negedge clk);
         check(fs_en, rows[i].a5[7]);
         check(track, rows[i].a5[7]);
         check(dith, rows[i].a5[6:5]);
         check(code, rows[i].a5[4:0]);
         check(volts, rows[i].v);
         check(div, rows[i].dv);
         check(ref_sel, rows[i].a8[7:6]);
         check(mult, rows[i].m);
         check(from_res, rows[i].a7[2]);
         check(rate, rows[i].rc);
         check(hm, rows[i].hm);
         @(posedge clk);
         $display("test row %0d done", i);
      end
      // Sync off, then a new counter value must not reach the PLL
      wr(0, 8'h7F);
      wr(1, 8'h12);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(div, 13'h0000);
      check(track, 1'b0);
      @(posedge clk);
      $display("test sync off done");
      // Low byte strobe off, unmapped places
      axi_write(32'h0000_0298, 8'h55, 4'hE, bsb_pkg::AXI_OKAY);
      rd(1, 8'h12);
      axi_write(32'h0000_0290, 8'h33, 4'h1, bsb_pkg::AXI_SLVERR);
      axi_read(32'h0000_0290, 32'h0, bsb_pkg::AXI_SLVERR);
      axi_write(32'h0000_0694, 8'hFF, 4'h1, bsb_pkg::AXI_SLVERR);
      rd(0, 8'h7F);
      $display("test refusals done");
      // Reset in mid-run clears the bank
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(2, 8'h00);
      check(div, 13'h0000);
      $display("test second reset done");
      report_and_stop();
   end

endmodule : testbench

`default_nettype wire
